// File: rtl/ptb_consts.vh
// constants for the pwm timebase block: register map, fields, resets, timing
//
// Contract
// (R1) Period is (period match plus one) times four clocks times the prescale factor.
// (R2) At count equal to period match: clear counter next tick, copy duty into shadow.
// (R3) At that boundary the pin goes high, unless the duty is zero.
// (R4) Postscaler affects only the update pulse, never the pwm frequency.
// (R5) Duty is ten bits: duty MSB register above control bits 5:4.
// (R6) High time is duty times one clock times the prescale factor.
// (R7) Duty writes accepted anytime, effective only after the next period match.
// (R8) In pwm mode the shadow register is read only.
// (R9) Shadow plus hidden two-bit latch double-buffer the duty, no glitches.
// (R10) Pin cleared when buffered duty equals counter with two-bit sub-count.
// (R11) Duty beyond the period never clears the pin: output stays high.
// (R12) Prescale factors one, four and sixteen, chosen in timebase control.
// (R13) Auto-shutdown exists on the first unit only.
// (R14) Software sets period, duty, direction, prescale and run, then pwm mode.
// (R15) Software clears the pin direction bit so the waveform reaches the pin.
// (R16) Enhanced output, shutdown and delay fields unimplemented read as zero.
// (R17) Mode select upper two bits both one selects pwm mode.
// (R18) Mode select all zeros turns the unit off and resets its state.
// (R19) Clearing second unit control forces its output latch low.
// (R20) Counter increments once per prescaled four-clock cycle while run is set.
`ifndef PTB_CONSTS_VH
`define PTB_CONSTS_VH

// byte offsets on the bus
`define PTB_OFF_COUNT    8'h00
`define PTB_OFF_PERIOD   8'h04
`define PTB_OFF_TBCTL    8'h08
`define PTB_OFF_U1DUTY   8'h0c
`define PTB_OFF_U1SHADOW 8'h10
`define PTB_OFF_U1CTL    8'h14
`define PTB_OFF_U2DUTY   8'h18
`define PTB_OFF_U2SHADOW 8'h1c
`define PTB_OFF_U2CTL    8'h20
`define PTB_OFF_SHDNCTL  8'h24
`define PTB_OFF_DELAY    8'h28
`define PTB_OFF_PINDIR   8'h2c

// timebase control fields
`define PTB_TB_PRESC_LSB 0
`define PTB_TB_RUN_BIT   2
`define PTB_TB_POST_LSB  3

// unit control fields
`define PTB_UC_DUTYLSB_LSB 4
`define PTB_UC_MODE_PWM    2'b11
`define PTB_UC_MODE_OFF    4'h0

// shutdown control fields
`define PTB_SD_STAT_BIT 7
`define PTB_SD_SRC_LSB  4
`define PTB_SD_STATE_LSB 2
`define PTB_DL_RESTART_BIT 7

// reset values
`define PTB_RST_PERIOD 8'hff
`define PTB_RST_PINDIR 2'b11

// one instruction cycle in clocks, and prescaler terminal counts
`define PTB_INSTR_CLKS 4
`define PTB_PRE1_LAST  6'h03
`define PTB_PRE4_LAST  6'h0f
`define PTB_PRE16_LAST 6'h3f

`endif

// File: rtl/ptb_pwm_timebase.v
// pwm timebase with two single-output pwm units behind an ahb-lite slave
`include "ptb_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// one pwm unit: duty registers, double buffer and output latch
module ptb_unit (
	input  wire       mclk,
	input  wire       rst,
	input  wire       boundary,
	input  wire [9:0] fine_cnt,
	input  wire       wr_duty,
	input  wire       wr_ctl,
	input  wire       wr_shadow,
	input  wire [7:0] wdata,
	output reg  [7:0] duty_reg,
	output reg  [5:0] ctl_reg,
	output reg  [7:0] shadow_reg,
	output reg        level_reg,
	output wire       pwm_mode
);

	reg  [1:0] lsb_latch_reg;
	reg        bnd_q;
	wire       unit_off;
	wire [9:0] duty_now;
	wire [9:0] duty_buf;

	// mode decode and duty composition
	assign pwm_mode = (ctl_reg[3:2] == `PTB_UC_MODE_PWM); // [R17]
	assign unit_off = (ctl_reg[3:0] == `PTB_UC_MODE_OFF);
	assign duty_now = {duty_reg, ctl_reg[5:4]};           // [R5]
	assign duty_buf = {shadow_reg, lsb_latch_reg};

	// register writes, buffering at the boundary and pin latch
	// the latch rises one clock after the boundary, in the first clock of
	// fine count zero, and falls at the end of the first clock of fine count
	// equal to the duty; so the high time is exactly duty fine steps long and
	// a duty of one step short of the period still leaves one low fine step, prescale factor clocks long
	always @(posedge mclk) begin
		if (rst) begin
			duty_reg      <= 8'h00;
			ctl_reg       <= 6'h00;
			shadow_reg    <= 8'h00;
			lsb_latch_reg <= 2'h0;
			level_reg     <= 1'b0;
			bnd_q         <= 1'b0;
		end else begin
			bnd_q <= boundary;
			if (wr_duty) begin
				duty_reg <= wdata; // [R7]
			end
			if (wr_ctl) begin
				ctl_reg <= wdata[5:0];
			end
			if (unit_off) begin
				// off clears the buffer and forces the latch low
				shadow_reg    <= 8'h00; // [R18]
				lsb_latch_reg <= 2'h0;
				level_reg     <= 1'b0;  // [R19]
			end else if (pwm_mode) begin
				if (boundary) begin
					shadow_reg    <= duty_now[9:2]; // [R2] [R9]
					lsb_latch_reg <= duty_now[1:0]; // [R9]
				end
				if (bnd_q) begin
					// period start: raise unless the latched duty is zero
					level_reg <= (duty_buf != 10'h000); // [R3]
				end else if (fine_cnt == duty_buf) begin
					// a duty past the period never matches here
					level_reg <= 1'b0; // [R10] [R11] [R6]
				end
			end else begin
				// shadow is writable outside pwm and off modes only
				level_reg <= 1'b0;
				if (wr_shadow) begin
					shadow_reg <= wdata; // [R8]
				end
			end
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////
// top: shared timebase, bus slave, shutdown and pins
module ptb_pwm_timebase (
	input  wire        mclk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        shutdown_req,
	output reg         pwm1_out,
	output reg         pwm1_oe,
	output reg         pwm2_out,
	output reg         pwm2_oe,
	output reg         update_pulse
);

	// timebase state
	reg  [7:0] count_reg;
	reg  [7:0] period_reg;
	reg  [6:0] tbctl_reg;
	reg  [5:0] pre_reg;
	reg  [3:0] post_reg;
	reg  [5:0] pre_last;
	reg  [1:0] sub_cnt;

	// enhanced leftovers and pin direction
	reg  [5:0] sdctl_reg;
	reg        shdn_stat_reg;
	reg        restart_reg;
	reg  [1:0] pindir_reg;

	// bus state
	reg  [7:0] addr_q;
	reg        wr_q;
	reg        rd_q;
	reg  [7:0] rmux;

	wire       run;
	wire       tick;
	wire       boundary;
	wire [9:0] fine_cnt;
	wire       accept;
	wire [7:0] wdata;
	wire       shdn_event;

	wire [7:0] u1_duty;
	wire [5:0] u1_ctl;
	wire [7:0] u1_shadow;
	wire       u1_level;
	wire       u1_pwm;
	wire [7:0] u2_duty;
	wire [5:0] u2_ctl;
	wire [7:0] u2_shadow;
	wire       u2_level;
	wire       u2_pwm;

	////////////////////////////////////////////////////////////////////////
	// prescaler and fine count

	// terminal count of the clock prescaler per selected factor
	always @* begin
		case (tbctl_reg[1:0])
			2'b00:   pre_last = `PTB_PRE1_LAST;  // [R12]
			2'b01:   pre_last = `PTB_PRE4_LAST;
			default: pre_last = `PTB_PRE16_LAST;
		endcase
	end

	// two-bit sub-count: the quarter-cycle phase or two prescaler bits
	always @* begin
		case (tbctl_reg[1:0])
			2'b00:   sub_cnt = pre_reg[1:0];
			2'b01:   sub_cnt = pre_reg[3:2];
			default: sub_cnt = pre_reg[5:4];
		endcase
	end

	assign run      = tbctl_reg[`PTB_TB_RUN_BIT];
	assign tick     = run && (pre_reg == pre_last);         // [R20] [R1]
	assign boundary = tick && (count_reg == period_reg);    // [R2]
	assign fine_cnt = {count_reg, sub_cnt};                 // [R10] [R6]

	////////////////////////////////////////////////////////////////////////
	// bus slave: writes have no wait state, reads have one
	// the address phase is captured into flops; the data phase then either
	// writes the selected register at its end or, for a read, spends one
	// wait cycle loading hrdata from the read mux, so hrdata is a clean flop

	assign accept    = hsel && hready && htrans[1];
	assign hreadyout = ~rd_q;
	assign hresp     = 1'b0;
	assign wdata     = hwdata[7:0];

	// address phase capture
	always @(posedge mclk) begin
		if (rst) begin
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			wr_q <= accept && hwrite;
			rd_q <= accept && !hwrite;
			if (accept) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// read mux, unimplemented enhanced bits read as zero
	always @* begin
		case (addr_q)
			`PTB_OFF_COUNT:    rmux = count_reg;
			`PTB_OFF_PERIOD:   rmux = period_reg;
			`PTB_OFF_TBCTL:    rmux = {1'b0, tbctl_reg};
			`PTB_OFF_U1DUTY:   rmux = u1_duty;
			`PTB_OFF_U1SHADOW: rmux = u1_shadow;
			`PTB_OFF_U1CTL:    rmux = {2'b00, u1_ctl};          // [R16]
			`PTB_OFF_U2DUTY:   rmux = u2_duty;
			`PTB_OFF_U2SHADOW: rmux = u2_shadow;
			`PTB_OFF_U2CTL:    rmux = {2'b00, u2_ctl};
			`PTB_OFF_SHDNCTL:  rmux = {shdn_stat_reg, sdctl_reg[5:1], 2'b00}; // [R16]
			`PTB_OFF_DELAY:    rmux = {restart_reg, 7'h00};    // [R16]
			`PTB_OFF_PINDIR:   rmux = {6'h00, pindir_reg};
			default:           rmux = 8'h00;
		endcase
	end

	// read data loaded in the wait cycle
	always @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_q) begin
			hrdata <= {24'h00_0000, rmux};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timebase counter, prescaler and postscaler
	// the prescaler counts clocks up to the terminal count of the selected
	// factor; each wrap is one tick of the counter, and a tick with the count
	// at the period match is the period boundary shared by both units

	always @(posedge mclk) begin
		if (rst) begin
			count_reg    <= 8'h00;
			period_reg   <= `PTB_RST_PERIOD;
			tbctl_reg    <= 7'h00;
			pre_reg      <= 6'h00;
			post_reg     <= 4'h0;
			update_pulse <= 1'b0;
		end else begin
			update_pulse <= 1'b0;
			if (wr_q && addr_q == `PTB_OFF_PERIOD) begin
				period_reg <= wdata;
			end
			if (wr_q && addr_q == `PTB_OFF_TBCTL) begin
				tbctl_reg <= wdata[6:0];
			end
			if (wr_q && addr_q == `PTB_OFF_COUNT) begin
				// a count write restarts the prescaler too
				count_reg <= wdata;
				pre_reg   <= 6'h00;
			end else if (run) begin
				if (tick) begin
					pre_reg <= 6'h00;
					if (boundary) begin
						count_reg <= 8'h00; // [R2] [R1]
					end else begin
						count_reg <= count_reg + 8'h01; // [R20]
					end
				end else begin
					pre_reg <= pre_reg + 6'h01;
				end
			end
			// postscaler only paces the update pulse
			if (boundary) begin
				if (post_reg == tbctl_reg[6:3]) begin
					post_reg     <= 4'h0;
					update_pulse <= 1'b1; // [R4]
				end else begin
					post_reg <= post_reg + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the two pwm units

	ptb_unit u_unit1 (
		.mclk       (mclk),
		.rst        (rst),
		.boundary   (boundary),
		.fine_cnt   (fine_cnt),
		.wr_duty    (wr_q && addr_q == `PTB_OFF_U1DUTY),
		.wr_ctl     (wr_q && addr_q == `PTB_OFF_U1CTL),
		.wr_shadow  (wr_q && addr_q == `PTB_OFF_U1SHADOW),
		.wdata      (wdata),
		.duty_reg   (u1_duty),
		.ctl_reg    (u1_ctl),
		.shadow_reg (u1_shadow),
		.level_reg  (u1_level),
		.pwm_mode   (u1_pwm)
	);

	ptb_unit u_unit2 (
		.mclk       (mclk),
		.rst        (rst),
		.boundary   (boundary),
		.fine_cnt   (fine_cnt),
		.wr_duty    (wr_q && addr_q == `PTB_OFF_U2DUTY),
		.wr_ctl     (wr_q && addr_q == `PTB_OFF_U2CTL),
		.wr_shadow  (wr_q && addr_q == `PTB_OFF_U2SHADOW),
		.wdata      (wdata),
		.duty_reg   (u2_duty),
		.ctl_reg    (u2_ctl),
		.shadow_reg (u2_shadow),
		.level_reg  (u2_level),
		.pwm_mode   (u2_pwm)
	);

	////////////////////////////////////////////////////////////////////////
	// auto-shutdown of the first unit

	// shutdown control layout in sdctl_reg: 5:3 source enables,
	// 2:1 shutdown pin state, 0 unused and always zero
	// any enabled source plus the request trips the shutdown
	assign shdn_event = (sdctl_reg[5:3] != 3'h0) && shutdown_req; // [R13]

	// status set by the event wins over a software clear
	always @(posedge mclk) begin
		if (rst) begin
			sdctl_reg     <= 6'h00;
			shdn_stat_reg <= 1'b0;
			restart_reg   <= 1'b0;
			pindir_reg    <= `PTB_RST_PINDIR;
		end else begin
			if (wr_q && addr_q == `PTB_OFF_SHDNCTL) begin
				sdctl_reg <= {wdata[6:2], 1'b0};
			end
			if (wr_q && addr_q == `PTB_OFF_DELAY) begin
				restart_reg <= wdata[`PTB_DL_RESTART_BIT];
			end
			if (wr_q && addr_q == `PTB_OFF_PINDIR) begin
				pindir_reg <= wdata[1:0];
			end
			if (shdn_event) begin
				shdn_stat_reg <= 1'b1; // [R13]
			end else if (restart_reg && boundary) begin
				// automatic restart at the next period boundary
				shdn_stat_reg <= 1'b0;
			end else if (wr_q && addr_q == `PTB_OFF_SHDNCTL) begin
				shdn_stat_reg <= wdata[`PTB_SD_STAT_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers: direction bit low enables the driver
	// both pins are registered once more so that the pads see flop outputs;
	// this adds one clock of latency but keeps high time and period intact

	always @(posedge mclk) begin
		if (rst) begin
			pwm1_out <= 1'b0;
			pwm1_oe  <= 1'b0;
			pwm2_out <= 1'b0;
			pwm2_oe  <= 1'b0;
		end else begin
			pwm2_out <= u2_level;
			pwm2_oe  <= ~pindir_reg[1]; // [R15]
			if (shdn_stat_reg && u1_pwm) begin
				// shutdown state: 00 low, 01 high, 1x released
				pwm1_out <= sdctl_reg[1] && !sdctl_reg[2]; // [R13]
				pwm1_oe  <= ~pindir_reg[0] && !sdctl_reg[2];
			end else begin
				pwm1_out <= u1_level;
				pwm1_oe  <= ~pindir_reg[0]; // [R15]
			end
		end
	end

endmodule

// File: testbench/ptb_chk_asserts.sv
// port checker for the pwm timebase
module ptb_chk (
	input logic        mclk,
	input logic        rst,
	input logic        hsel,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata,
	input logic        pwm1_out,
	input logic        pwm1_oe,
	input logic        pwm2_out,
	input logic        update_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// bus timing: one wait cycle on reads, none on writes
	property p_rd;
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd: assert property (p_rd) else $error("read wait");
	property p_wr;
		hsel && hready && htrans[1] && hwrite |=> hreadyout;
	endproperty
	a_wr: assert property (p_wr) else $error("write wait");
	property p_ok;
		!hresp;
	endproperty
	a_ok: assert property (p_ok) else $error("error response");
	property p_hi;
		hrdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits");
	// pulses and pin rises are spaced by at least one shortest period
	property p_upd;
		update_pulse |=> (!update_pulse)[*3];
	endproperty
	a_upd: assert property (p_upd) else $error("update pulse");
	property p_gap1;
		$rose(pwm1_out) |=> (!$rose(pwm1_out))[*3];
	endproperty
	a_gap1: assert property (p_gap1) else $error("unit one period");
	property p_gap2;
		$rose(pwm2_out) |=> (!$rose(pwm2_out))[*3];
	endproperty
	a_gap2: assert property (p_gap2) else $error("unit two period");
	// reset leaves the pins quiet
	property p_rst;
		$past(rst) |-> !pwm1_oe && !pwm1_out && !pwm2_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
endmodule
bind ptb_pwm_timebase ptb_chk u_chk (.mclk, .rst, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .pwm1_out, .pwm1_oe, .pwm2_out, .update_pulse);

// File: testbench/ptb_load_model.sv
// load on the unit one pin: measures high time and period in clocks
module ptb_load_model (
	input  logic        mclk,
	input  logic        drv,
	input  logic        oe,
	output logic [15:0] hi_len,
	output logic [15:0] per_len
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        pin, pin_d;
	logic [15:0] hi_c, per_c;
	// a pull-down holds the pin low while it is not driven
	assign pin = oe ? drv : 1'b0;
	// count clocks high and clocks between rising edges
	always @(posedge mclk) begin
		pin_d <= pin;
		hi_c <= pin ? hi_c + 16'h1 : 16'h0;
		per_c <= (pin && !pin_d) ? 16'h1 : per_c + 16'h1;
		if (!pin && pin_d)
			hi_len <= hi_c;
		if (pin && !pin_d)
			per_len <= per_c;
	end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the pwm timebase
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, rdy, hresp, o1, e1, o2, e2, upd;
	logic        rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sdn = 1'b0;
	int          n_upd = 0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [31:0] seed = 32'hfa5f;
	logic [15:0] hi_len, per_len;
	int          n_fail = 0, checks_done = 0, cyc = 0;
	ptb_pwm_timebase uut (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
		.hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .shutdown_req(sdn),
		.pwm1_out(o1), .pwm1_oe(e1), .pwm2_out(o2), .pwm2_oe(e2), .update_pulse(upd));
	ptb_load_model ld (.mclk(mclk), .drv(o1), .oe(e1), .hi_len(hi_len), .per_len(per_len));
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (upd === 1'b1)
			n_upd <= n_upd + 1;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////
	function automatic int rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return int'(seed[15:0]);
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// wait for the edge at which hready is high
	task automatic wt();
		do
			@(negedge mclk);
		while (rdy !== 1'b1);
		@(posedge mclk);
	endtask
	// single word transfer; a read compares against d
	task automatic xfer(input logic w, input logic [7:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wt();
		if (!w)
			chk($sformatf("reg %h", a), {8'h0, d}, {8'h0, hrdata[7:0]});
	endtask
	// measure a settled pulse on pin one
	task automatic wave(input int h, p);
		repeat (3) @(posedge o1);
		@(negedge mclk);
		chk("high time", h[15:0], hi_len);
		chk("period", p[15:0], per_len);
		@(posedge mclk);
	endtask
	// let the pin settle, then count cycles off the expected level
	task automatic lvl(input logic u, v, input int len);
		int n;
		n = 0;
		repeat (2 * len) @(posedge mclk);
		repeat (len) begin
			@(negedge mclk);
			n += ((u ? o2 : o1) !== v);
		end
		chk("pin level", 16'h0, n[15:0]);
		@(posedge mclk);
	endtask
	// main sequence
	initial begin
		int s, ps, p, d, d2, per;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		xfer(1'b0, 8'h04, 8'hff); // period match resets to all ones
		xfer(1'b0, 8'h2c, 8'h03); // both pins released
		xfer(1'b1, 8'h30, 8'h5a);
		xfer(1'b0, 8'h30, 8'h00); // unmapped place reads zero
		xfer(1'b1, 8'h20, 8'hff);
		xfer(1'b0, 8'h20, 8'h3f);
		xfer(1'b1, 8'h28, 8'h7f);
		xfer(1'b0, 8'h28, 8'h00);
		for (s = 0; s < 3; s++) begin
			ps = 1 << (2 * s);
			p = 3 + rnd() % 4;
			d = 1 + rnd() % (4 * p + 3);
			per = (p + 1) * 4 * ps;
			xfer(1'b1, 8'h04, p[7:0]);
			xfer(1'b1, 8'h0c, d[9:2]);
			xfer(1'b1, 8'h14, {2'h0, d[1:0], 4'h0});
			xfer(1'b1, 8'h2c, 8'h00);
			xfer(1'b1, 8'h00, 8'h00);
			xfer(1'b1, 8'h08, {1'b0, s[3:0], 1'b1, s[1:0]});
			xfer(1'b1, 8'h14, {2'h0, d[1:0], 4'hc});
			wave(d * ps, per);
			d2 = d < 8 ? d + 4 : d - 4;
			@(posedge o1); // keep the shadow checks clear of a boundary
			xfer(1'b1, 8'h0c, d2[9:2]);
			xfer(1'b0, 8'h10, d[9:2]);
			xfer(1'b1, 8'h10, 8'h55);
			xfer(1'b0, 8'h10, d[9:2]);
			wave(d2 * ps, per);
			xfer(1'b0, 8'h10, d2[9:2]);
		end
		xfer(1'b1, 8'h0c, 8'hff);
		lvl(1'b0, 1'b1, per);
		xfer(1'b1, 8'h14, 8'h00);
		xfer(1'b0, 8'h10, 8'h00);
		lvl(1'b0, 1'b0, 8);
		xfer(1'b1, 8'h0c, 8'h00);
		xfer(1'b1, 8'h14, 8'h0c);
		lvl(1'b0, 1'b0, per);
		xfer(1'b1, 8'h18, 8'hff);
		xfer(1'b1, 8'h20, 8'h0c);
		lvl(1'b1, 1'b1, per);
		xfer(1'b1, 8'h20, 8'h00);
		lvl(1'b1, 1'b0, 8);
		xfer(1'b1, 8'h24, 8'h14);
		sdn <= 1'b1;
		lvl(1'b0, 1'b1, 8);
		xfer(1'b0, 8'h24, 8'h94);
		chk("pin enables", 16'h3, {14'h0, e2, e1});
		chk("update pulses", 16'h1, {15'h0, n_upd > 0});
		finish_test();
	end
endmodule
